/* File: rtl/sps_pkg.sv */
package sps_pkg;
   // timing
   localparam int unsigned CLK_MHZ           = 100;
   localparam int unsigned SENSE_PERIOD_US   = 1024;
   localparam int unsigned DEBOUNCE_US       = 32;
   localparam int unsigned FLOAT_HOLD_MS     = 64;
   localparam int unsigned SENSE_PERIOD_CYC  = SENSE_PERIOD_US * CLK_MHZ;
   localparam int unsigned DEBOUNCE_CYC      = DEBOUNCE_US * CLK_MHZ;
   localparam int unsigned FLOAT_HOLD_CYC    = FLOAT_HOLD_MS * 1000 * CLK_MHZ;
   // step period: STEP_BASE_CYC plus the velocity headroom below full scale
   localparam int unsigned STEP_BASE_CYC     = 20;
   // reset value, safe position disable code and shift
   localparam logic [15:0] POS_RESET         = 16'h0000;
   localparam logic [10:0] SAFE_DISABLED     = 11'h400;
   localparam int unsigned SAFE_SHIFT        = 5;

   typedef enum logic [1:0] {
      SPS_ADDR_FLOAT = 2'b00,
      SPS_ADDR_LOW   = 2'b01,
      SPS_ADDR_HIGH  = 2'b10
   } sps_addr_t;

   typedef enum logic [2:0] {
      SPS_MV_IDLE   = 3'b000,
      SPS_MV_RUN    = 3'b001,
      SPS_MV_LEG1   = 3'b010,
      SPS_MV_LEG2   = 3'b011,
      SPS_MV_SAFE   = 3'b100
   } sps_mode_t;
endpackage : sps_pkg

/* File: rtl/sps_addr_sense.sv */
module sps_addr_sense #(
   parameter int unsigned PERIOD_CYC   = sps_pkg::SENSE_PERIOD_CYC,
   parameter int unsigned DEBOUNCE_CYC = sps_pkg::DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // analog front end
   input  wire logic              addr_pin_comparator_out,
   output logic                   high_side_sense_drive,
   output logic                   low_side_sense_drive,
   // result
   output sps_pkg::sps_addr_t     addr_state,
   output logic                   addr_bit
);
   typedef struct packed {
      logic [23:0]         tmr;
      logic                phase_hs;
      logic                drv;
      sps_pkg::sps_addr_t  st;
   } sps_as_t;

   sps_as_t q, d;

   always_comb begin
      d = q;
      if (q.drv) begin
         if (q.tmr == 24'(DEBOUNCE_CYC - 1)) begin
            // comparator is settled after the debounce interval [RULE23]
            d.drv = 1'b0;
            if (q.phase_hs) begin
               if (addr_pin_comparator_out) d.st = sps_pkg::SPS_ADDR_LOW;        // [RULE20]
               else if (q.st == sps_pkg::SPS_ADDR_LOW) d.st = sps_pkg::SPS_ADDR_FLOAT; // [RULE22] [RULE21]
            end else begin
               if (addr_pin_comparator_out) d.st = sps_pkg::SPS_ADDR_HIGH;       // [RULE19]
               else if (q.st == sps_pkg::SPS_ADDR_HIGH) d.st = sps_pkg::SPS_ADDR_FLOAT; // [RULE22] [RULE21]
            end
         end
      end
      if (q.tmr == 24'(PERIOD_CYC - 1)) begin
         d.tmr      = '0;
         d.drv      = 1'b1;                 // [RULE24]
         d.phase_hs = ~q.phase_hs;          // [RULE18]
      end else begin
         d.tmr = q.tmr + 24'h000001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '{tmr: '0, phase_hs: 1'b1, drv: 1'b0, st: sps_pkg::SPS_ADDR_FLOAT};
      end else begin
         q <= d;
      end
   end

   assign high_side_sense_drive = q.drv & q.phase_hs;
   assign low_side_sense_drive  = q.drv & ~q.phase_hs;
   assign addr_state            = q.st;
   assign addr_bit              = (q.st == sps_pkg::SPS_ADDR_HIGH);

   a_drive_exclusive: assert property (@(posedge clk) disable iff (rst) // [RULE18]
      !(high_side_sense_drive && low_side_sense_drive))                            // [RULE18]
      else $error("both sense switches driven");
   a_ls_high: assert property (@(posedge clk) disable iff (rst) // [RULE19]
      (q.drv && !q.phase_hs && q.tmr == 24'(DEBOUNCE_CYC - 1) && addr_pin_comparator_out)
      |=> addr_state == sps_pkg::SPS_ADDR_HIGH)                                    // [RULE19]
      else $error("low side hit did not give high");
   a_hs_low: assert property (@(posedge clk) disable iff (rst) // [RULE20]
      (q.drv && q.phase_hs && q.tmr == 24'(DEBOUNCE_CYC - 1) && addr_pin_comparator_out)
      |=> addr_state == sps_pkg::SPS_ADDR_LOW)                                     // [RULE20]
      else $error("high side hit did not give low");
   a_state_hold: assert property (@(posedge clk) disable iff (rst) // [RULE23]
      !(q.drv && q.tmr == 24'(DEBOUNCE_CYC - 1)) |=> $stable(addr_state))           // [RULE23]
      else $error("address state changed outside evaluation");
endmodule : sps_addr_sense

/* File: rtl/sps_sequencer.sv */
// Summary of operation
// RULE1: each move ramps vmin to vmax, then decelerates symmetrically to target.
// RULE2: same-direction command during deceleration re-accelerates without idle gap.
// RULE3: target reached exactly; velocity rounding cleared on return to vmin.
// RULE4: dual leg one goes to first target with command velocities, stored acceleration.
// RULE5: dual leg two goes to second target at command vmin, no ramp.
// RULE6: after leg two actual position cleared, target position untouched.
// RULE7: safe position enabled means a move there after the dual sequence.
// RULE8: dual sequence completion sets the referenced flag.
// RULE9: dual sequence ignores commands; only shutdown or immediate halt abort it.
// RULE10: host should not start dual sequence while a motion is in progress.
// RULE11: dual start loads target with safe position if enabled, else zero.
// RULE12: goto and goto-safe during dual sequence are buffered, run afterwards.
// RULE13: both status reads are served during a dual sequence.
// RULE14: dual command velocities apply only to it; stored velocities return afterwards.
// RULE15: zero, dual and ramped-halt commands during dual sequence are discarded.
// RULE16: parameter writes during dual apply immediately except velocities.
// RULE17: positions wrap on a circle; goto takes the shortest direction.
// RULE18: sense logic alternates high and low side drives, never both.
// RULE19: low side phase with comparator high gives state High.
// RULE20: high side phase with comparator high gives state Low.
// RULE21: comparator low keeps Float, keeps Low in low phase, High in high phase.
// RULE22: comparator low moves High in low phase or Low in high phase to Float.
// RULE23: comparator only interpreted after the debounce interval.
// RULE24: sensing repeats periodically; High is address one, Low address zero.
// RULE25: Float persisting for the hold time triggers a move to safe position.
module sps_sequencer #(
   parameter int unsigned FLOAT_HOLD_CYC = sps_pkg::FLOAT_HOLD_CYC,
   parameter int unsigned PERIOD_CYC     = sps_pkg::SENSE_PERIOD_CYC,
   parameter int unsigned DEBOUNCE_CYC   = sps_pkg::DEBOUNCE_CYC,
   parameter int unsigned STEP_BASE_CYC  = sps_pkg::STEP_BASE_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // decoded commands, one-cycle pulses
   input  wire logic        goto_position_cmd,
   input  wire logic        goto_safe_position_cmd,
   input  wire logic        dual_speed_reference_cmd,
   input  wire logic        immediate_halt_cmd,
   input  wire logic        ramped_halt_cmd,
   input  wire logic        zero_position_cmd,
   input  wire logic        motion_param_write_cmd,
   input  wire logic        status_read_one_cmd,
   input  wire logic        status_read_two_cmd,
   // command data
   input  wire logic [15:0] cmd_position,
   input  wire logic [15:0] first_leg_target,
   input  wire logic [15:0] second_leg_target,
   input  wire logic [3:0]  cmd_vmin,
   input  wire logic [3:0]  cmd_vmax,
   input  wire logic [3:0]  param_vmin,
   input  wire logic [3:0]  param_vmax,
   input  wire logic [3:0]  param_accel,
   input  wire logic        accel_shape_select,
   input  wire logic [10:0] safe_position_value,
   input  wire logic        motor_shutdown,
   // address pin front end
   input  wire logic        addr_pin_comparator_out,
   output logic             high_side_sense_drive,
   output logic             low_side_sense_drive,
   // status
   output logic [15:0]      actual_position,
   output logic [15:0]      target_position,
   output logic             step_pulse,
   output logic             step_dir,
   output logic             moving,
   output logic             dual_active,
   output logic             referenced,
   output logic             addr_bit,
   output logic             status_snapshot_valid,
   output logic [15:0]      status_snapshot_pos
);
   typedef struct packed {
      sps_pkg::sps_mode_t mode;
      logic [15:0] act;
      logic [15:0] tag;
      logic [15:0] leg2;
      logic [3:0]  vmin;
      logic [3:0]  vmax;
      logic [7:0]  vel;       // velocity index scaled by 16
      logic [7:0]  acc_cnt;
      logic [11:0] step_cnt;
      logic        dir;
      logic        step;
      logic        ramp;
      logic        buf_valid;
      logic [15:0] buf_pos;
      logic        refd;
      logic [31:0] float_cnt;
      logic        float_fired;
      logic        snap_v;
      logic [15:0] snap_pos;
      logic        hs_q;
      logic        ls_q;
      logic        abit;
   } sps_state_t;

   sps_state_t q, d;
   sps_pkg::sps_addr_t a_state;
   logic hs_w, ls_w, abit_w;

   sps_addr_sense #(.PERIOD_CYC(PERIOD_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) u_sense (
      .clk                     (clk),
      .rst                     (rst),
      .addr_pin_comparator_out (addr_pin_comparator_out),
      .high_side_sense_drive   (hs_w),
      .low_side_sense_drive    (ls_w),
      .addr_state              (a_state),
      .addr_bit                (abit_w)
   );

   logic        safe_en;
   logic [15:0] safe_pos;
   logic [15:0] goal;
   logic [15:0] gdiff;
   logic [15:0] gdist;
   logic [15:0] decel_steps;
   logic        dual_mode;
   logic [7:0]  vmin16;
   logic [7:0]  vmax16;
   logic [11:0] period;

   always_comb begin
      safe_en     = (safe_position_value != sps_pkg::SAFE_DISABLED);
      safe_pos    = {safe_position_value, 5'h00};
      dual_mode   = (q.mode == sps_pkg::SPS_MV_LEG1) || (q.mode == sps_pkg::SPS_MV_LEG2);
      // leg one targets first position, leg two the second [RULE4] [RULE5]
      goal        = (q.mode == sps_pkg::SPS_MV_LEG1) ? first_leg_target :
                    (q.mode == sps_pkg::SPS_MV_LEG2) ? q.leg2 : q.tag;
      // two's complement difference wraps, so its sign is the short way [RULE17]
      gdiff       = goal - q.act;
      gdist       = gdiff[15] ? (16'h0000 - gdiff) : gdiff;
      vmin16      = {q.vmin, 4'h0};
      vmax16      = {q.vmax, 4'h0};
      // steps needed to slow down, proportional to velocity above vmin
      decel_steps = {8'h00, q.vel - vmin16} >> 2;
      period      = 12'(STEP_BASE_CYC) + {4'h0, 8'hff - q.vel};
   end

   always_comb begin
      d      = q;
      d.step = 1'b0;
      d.snap_v = 1'b0;
      d.hs_q = hs_w;
      d.ls_q = ls_w;
      d.abit = abit_w;

      // status reads always served, dual or not [RULE13]
      if (status_read_one_cmd || status_read_two_cmd) begin
         d.snap_v   = 1'b1;
         d.snap_pos = q.act;
      end

      // velocities follow stored parameters except during dual legs [RULE14] [RULE16]
      if (!dual_mode) begin
         d.vmin = param_vmin;
         d.vmax = param_vmax;
      end

      // float debounce before triggering the safe move [RULE25]
      if (a_state == sps_pkg::SPS_ADDR_FLOAT) begin
         if (q.float_cnt != 32'(FLOAT_HOLD_CYC)) d.float_cnt = q.float_cnt + 32'h1;
      end else begin
         d.float_cnt   = '0;
         d.float_fired = 1'b0;
      end

      if (dual_mode) begin
         // goto commands buffered; zero, dual, ramped halt dropped [RULE12] [RULE15] [RULE9]
         if (goto_position_cmd) begin
            d.buf_valid = 1'b1;
            d.buf_pos   = cmd_position;
         end else if (goto_safe_position_cmd && safe_en) begin
            d.buf_valid = 1'b1;
            d.buf_pos   = safe_pos;
         end
      end else begin
         if (dual_speed_reference_cmd) begin
            d.mode = sps_pkg::SPS_MV_LEG1;
            d.tag  = safe_en ? safe_pos : sps_pkg::POS_RESET;    // [RULE11]
            d.leg2 = second_leg_target;
            d.vmin = cmd_vmin;                                  // [RULE4]
            d.vmax = cmd_vmax;
            d.buf_valid = 1'b0;
         end else if (zero_position_cmd) begin
            d.act = sps_pkg::POS_RESET;
            d.tag = sps_pkg::POS_RESET;
         end else if (ramped_halt_cmd) begin
            d.tag = q.act + (q.dir ? -decel_steps : decel_steps);
         end else if (goto_position_cmd) begin
            d.tag  = cmd_position;
            d.mode = sps_pkg::SPS_MV_RUN;
         end else if (goto_safe_position_cmd && safe_en) begin
            d.tag  = safe_pos;
            d.mode = sps_pkg::SPS_MV_RUN;
         end else if (a_state == sps_pkg::SPS_ADDR_FLOAT && !q.float_fired
                      && q.float_cnt == 32'(FLOAT_HOLD_CYC) && safe_en) begin
            d.float_fired = 1'b1;
            d.tag  = safe_pos;
            d.mode = sps_pkg::SPS_MV_RUN;
         end
      end

      // leg one targets first position, leg two the second [RULE4] [RULE5]
      begin
         if (q.mode == sps_pkg::SPS_MV_IDLE) begin
            d.vel = vmin16;                                      // [RULE3]
         end else if (gdist == 16'h0000) begin
            // exact arrival; rounding cleared by restarting at vmin [RULE3]
            d.vel = vmin16;
            d.step_cnt = '0;
            case (q.mode)
               sps_pkg::SPS_MV_LEG1: d.mode = sps_pkg::SPS_MV_LEG2;
               sps_pkg::SPS_MV_LEG2: begin
                  d.act  = sps_pkg::POS_RESET;                   // [RULE6]
                  d.refd = 1'b1;                                 // [RULE8]
                  // safe move already loaded into the target [RULE7]
                  d.mode = (safe_en && q.tag != 16'h0000) ? sps_pkg::SPS_MV_SAFE
                                                          : sps_pkg::SPS_MV_IDLE;
                  // a goto taken in this very cycle still counts as buffered [RULE12]
                  if (d.buf_valid) begin
                     d.tag       = d.buf_pos;
                     d.buf_valid = 1'b0;
                     d.mode      = sps_pkg::SPS_MV_RUN;
                  end
               end
               // a command landing on the arrival cycle keeps its new move [RULE2]
               default: if (d.tag == q.tag && d.mode == q.mode) d.mode = sps_pkg::SPS_MV_IDLE;
            endcase
         end else begin
            d.dir = gdiff[15];                                   // [RULE17]
            if (q.step_cnt >= period) begin
               d.step_cnt = '0;
               d.step     = 1'b1;
               d.act      = gdiff[15] ? q.act - 16'h0001 : q.act + 16'h0001;
               // ramp: accelerate while far, decelerate near goal [RULE1] [RULE2]
               if (q.mode == sps_pkg::SPS_MV_LEG2) begin
                  d.vel = vmin16;                                // [RULE5]
               end else if ({8'h00, q.vel - vmin16} >> 2 >= gdist) begin
                  if (q.vel > vmin16) d.vel = q.vel - {4'h0, param_accel} - 8'h01;
                  if (d.vel < vmin16 || d.vel > q.vel) d.vel = vmin16;
               end else if (q.vel < vmax16) begin
                  d.vel = q.vel + {4'h0, param_accel} + 8'h01;
                  if (d.vel > vmax16 || d.vel < q.vel) d.vel = vmax16;
               end else if (q.vel > vmax16) begin
                  d.vel = vmax16;
               end
               if (accel_shape_select) d.vel = vmin16;
            end else begin
               d.step_cnt = q.step_cnt + 12'h001;
            end
         end
      end

      // immediate halt and shutdown abort anything, dual included [RULE9]
      if (immediate_halt_cmd || motor_shutdown) begin
         d.mode      = sps_pkg::SPS_MV_IDLE;
         d.tag       = q.act;
         d.vel       = vmin16;
         d.buf_valid = 1'b0;
         d.step      = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign actual_position       = q.act;
   assign target_position       = q.tag;
   assign step_pulse            = q.step;
   assign step_dir              = q.dir;
   assign moving                = (q.mode != sps_pkg::SPS_MV_IDLE);
   assign dual_active           = (q.mode == sps_pkg::SPS_MV_LEG1) ||
                                  (q.mode == sps_pkg::SPS_MV_LEG2);
   assign referenced            = q.refd;
   assign high_side_sense_drive = q.hs_q;
   assign low_side_sense_drive  = q.ls_q;
   assign addr_bit              = q.abit;
   assign status_snapshot_valid = q.snap_v;
   assign status_snapshot_pos   = q.snap_pos;

   sequence s_leg2_done;
      q.mode == sps_pkg::SPS_MV_LEG2 && q.act == q.leg2 && !immediate_halt_cmd && !motor_shutdown;
   endsequence

   a_leg2_zero: assert property (@(posedge clk) disable iff (rst) // [RULE6] [RULE8]
      s_leg2_done |=> actual_position == 16'h0000 && referenced)            // [RULE6]
      else $error("leg two end did not zero position");
   a_leg2_tag: assert property (@(posedge clk) disable iff (rst) // [RULE6]
      (s_leg2_done and (!q.buf_valid && !goto_position_cmd && !goto_safe_position_cmd))
      |=> target_position == $past(q.tag))
      else $error("leg two changed target");
   a_dual_start: assert property (@(posedge clk) disable iff (rst) // [RULE11]
      (dual_speed_reference_cmd && !dual_active && !immediate_halt_cmd && !motor_shutdown)
      |=> target_position == (safe_en ? safe_pos : 16'h0000))              // [RULE11]
      else $error("dual start target wrong");
   a_dual_drop: assert property (@(posedge clk) disable iff (rst) // [RULE15]
      (dual_active && zero_position_cmd && q.mode == sps_pkg::SPS_MV_LEG1
       && q.act != 16'h0000 && q.act != 16'h0001 && q.act != 16'hffff
       && q.act != first_leg_target)
      |=> actual_position != 16'h0000)                                      // [RULE15]
      else $error("zero command acted during dual");
   a_halt_abort: assert property (@(posedge clk) disable iff (rst) // [RULE9]
      immediate_halt_cmd |=> !moving && !step_pulse)                          // [RULE9]
      else $error("halt did not stop");
   a_leg2_slow: assert property (@(posedge clk) disable iff (rst) // [RULE5]
      q.mode == sps_pkg::SPS_MV_LEG2 |-> q.vel == vmin16)                     // [RULE5]
      else $error("leg two ramped");
   a_status_served: assert property (@(posedge clk) disable iff (rst) // [RULE13]
      (status_read_one_cmd || status_read_two_cmd) |=> status_snapshot_valid)
      else $error("status not served");
   a_vel_bound: assert property (@(posedge clk) disable iff (rst) // [RULE1]
      moving |-> q.vel <= vmax16 || q.vel == vmin16)                         // [RULE1]
      else $error("velocity above top");
endmodule : sps_sequencer

/* File: tb/sps_pin_model.sv */
module sps_pin_model (
   // clock
   input  wire logic       clk,
   // pin condition: 0 open, 1 tied to ground, 2 tied to supply
   input  wire logic [1:0] pin_mode,
   // sense switches and comparator
   input  wire logic       high_side_sense_drive,
   input  wire logic       low_side_sense_drive,
   output logic            addr_pin_comparator_out
);
   timeunit 1ns;
   timeprecision 100ps;

   logic idle_q = 1'b0;

   // with no switch closed nothing is sensed, so the output chatters instead of holding
   always @(posedge clk) idle_q <= ~idle_q;

   always_comb begin
      if (high_side_sense_drive) addr_pin_comparator_out = (pin_mode == 2'h1);
      else if (low_side_sense_drive) addr_pin_comparator_out = (pin_mode == 2'h2);
      else addr_pin_comparator_out = idle_q;
   end
endmodule : sps_pin_model

/* File: tb/sps_sequencer_tb_top.sv */
module sps_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [8:0]  cmd = 9'h000;
   logic [15:0] cmd_position = 16'h0000;
   logic [15:0] first_leg = 16'h0000;
   logic [15:0] second_leg = 16'h0000;
   logic [3:0]  vmin = 4'h8;
   logic [3:0]  vmax = 4'hf;
   logic [10:0] safe_value = 11'h400;
   logic        motor_shutdown = 1'b0;
   logic [1:0]  pin_mode = 2'h2;
   logic        comp, hs, ls, step_pulse, step_dir, moving, dual_active, referenced;
   logic        addr_bit, snap_valid;
   logic [15:0] actual_position, target_position, snap_pos, t0;
   int          fails = 0;
   int          cmp_count = 0;
   int          both_on = 0;

   always #5 clk = ~clk;
   always @(negedge clk) if (hs === 1'b1 && ls === 1'b1) both_on++;

   sps_pin_model sps_pin_model_i (.clk(clk), .pin_mode(pin_mode), .high_side_sense_drive(hs),
      .low_side_sense_drive(ls), .addr_pin_comparator_out(comp));

   sps_sequencer #(.FLOAT_HOLD_CYC(50), .PERIOD_CYC(64), .DEBOUNCE_CYC(8)) sps_sequencer_i (
      .clk(clk), .rst(rst), .goto_position_cmd(cmd[0]), .goto_safe_position_cmd(cmd[1]),
      .dual_speed_reference_cmd(cmd[2]), .immediate_halt_cmd(cmd[3]), .ramped_halt_cmd(cmd[4]),
      .zero_position_cmd(cmd[5]), .motion_param_write_cmd(cmd[6]), .status_read_one_cmd(cmd[7]),
      .status_read_two_cmd(cmd[8]), .cmd_position(cmd_position), .first_leg_target(first_leg),
      .second_leg_target(second_leg), .cmd_vmin(vmin), .cmd_vmax(vmax), .param_vmin(vmin),
      .param_vmax(vmax), .param_accel(4'h4), .accel_shape_select(1'b0),
      .safe_position_value(safe_value), .motor_shutdown(motor_shutdown),
      .addr_pin_comparator_out(comp), .high_side_sense_drive(hs), .low_side_sense_drive(ls),
      .actual_position(actual_position), .target_position(target_position),
      .step_pulse(step_pulse), .step_dir(step_dir), .moving(moving), .dual_active(dual_active),
      .referenced(referenced), .addr_bit(addr_bit), .status_snapshot_valid(snap_valid),
      .status_snapshot_pos(snap_pos));

   task automatic finish_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic pulse(input int unsigned idx);
      @(negedge clk);
      cmd[idx] = 1'b1;
      @(negedge clk);
      cmd = 9'h000;
      @(negedge clk);
   endtask : pulse

   task automatic status_read(input int unsigned idx);
      logic        seen;
      logic [15:0] pos0;
      seen = 1'b0;
      @(negedge clk);
      pos0     = actual_position;
      cmd[idx] = 1'b1;
      repeat (3) begin
         @(negedge clk);
         cmd = 9'h000;
         if (snap_valid === 1'b1) begin
            seen = 1'b1;
            check(snap_pos, pos0);
         end
      end
      check({15'h0000, seen}, 16'h0001);
   endtask : status_read

   // dual_only waits for the reference sequence alone, otherwise for all motion to end
   task automatic wait_idle(input logic dual_only);
      int n;
      n = 0;
      while ((dual_active !== 1'b0 || (!dual_only && moving !== 1'b0)) && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20000) begin
         fails++;
         finish_test();
      end
   endtask : wait_idle

   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check(actual_position, 16'h0000);
      cmd_position = 16'h0003;
      pulse(0);
      check(target_position, 16'h0003);
      check({15'h0000, moving}, 16'h0001);
      wait_idle(1'b0);
      check(actual_position, 16'h0003);
      cmd_position = 16'hfffe;
      pulse(0);
      for (int n = 0; n < 1000 && step_pulse !== 1'b1; n++) @(negedge clk);
      if (step_pulse !== 1'b1) begin
         fails++;
         finish_test();
      end
      check({15'h0000, step_dir}, 16'h0001);
      wait_idle(1'b0);
      check(actual_position, 16'hfffe);
      $display("test plain moves done");
      first_leg = 16'h0001;
      second_leg = 16'h0002;
      pulse(2);
      check(target_position, 16'h0000);
      cmd_position = 16'h0003;
      pulse(0);
      status_read(7);
      status_read(8);
      wait_idle(1'b1);
      check(actual_position, 16'h0000);
      check({15'h0000, referenced}, 16'h0001);
      wait_idle(1'b0);
      check(actual_position, 16'h0003);
      $display("test reference with buffered goto done");
      safe_value = 11'h001;
      first_leg = 16'h0005;
      second_leg = 16'h0004;
      pulse(2);
      check(target_position, 16'h0020);
      pulse(5);
      pulse(4);
      pulse(2);
      check(target_position, 16'h0020);
      check(actual_position, 16'h0003);
      wait_idle(1'b0);
      repeat (20) @(negedge clk);
      check(actual_position, 16'h0020);
      $display("test reference with safe move done");
      safe_value = 11'h400;
      first_leg = 16'h0100;
      pulse(2);
      repeat (50) @(negedge clk);
      pulse(3);
      repeat (5) @(negedge clk);
      check({15'h0000, dual_active}, 16'h0000);
      wait_idle(1'b0);
      $display("test halt during reference done");
      check({15'h0000, addr_bit}, 16'h0001);
      pin_mode = 2'h1;
      repeat (256) @(negedge clk);
      check({15'h0000, addr_bit}, 16'h0000);
      t0 = target_position;
      safe_value = 11'h002;
      repeat (256) @(negedge clk);
      check(target_position, t0);
      pin_mode = 2'h0;
      repeat (400) @(negedge clk);
      check(target_position, 16'h0040);
      wait_idle(1'b0);
      check(16'(both_on), 16'h0000);
      $display("test address sense done");
      finish_test();
   end
endmodule : sps_sequencer_tb_top
